// ### logic/rbac_pkg.sv
package rbac_pkg;

  // ----------------------------------------------------------------
  // bank geometry
  // ----------------------------------------------------------------
  localparam int RBAC_NUM_REGS = 4;
  localparam int RBAC_REG_W    = 16;
  localparam int RBAC_ADDR_W   = 2;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [RBAC_ADDR_W-1:0] RBAC_IDX_CTRL = 2'h0;
  localparam logic [RBAC_ADDR_W-1:0] RBAC_IDX_STAT = 2'h1;
  localparam logic [RBAC_ADDR_W-1:0] RBAC_IDX_EVT  = 2'h2;
  localparam logic [RBAC_ADDR_W-1:0] RBAC_IDX_MISC = 2'h3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RBAC_CTRL_SOFT_REQ_BIT = 0;
  localparam int RBAC_CTRL_LITE_REQ_BIT = 1;
  localparam int RBAC_MISC_RSVD_ERR_BIT = 8;

  // ----------------------------------------------------------------
  // bit access attributes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    RBAC_RW                       = 4'h0,
    RBAC_RO                       = 4'h1,
    RBAC_LATCH_LOW_CLEAR_ON_READ  = 4'h2,
    RBAC_LATCH_HIGH_CLEAR_ON_READ = 4'h3,
    RBAC_SELF_CLEARING            = 4'h4,
    RBAC_SELF_SETTING             = 4'h5,
    RBAC_READONLY_STICKY_HIGH     = 4'h6,
    RBAC_WRITE_ONE_TO_CLEAR       = 4'h7,
    RBAC_READ_TO_CLEAR            = 4'h8,
    RBAC_RESERVED                 = 4'h9
  } rbac_attr_e;

  // one nibble per bit, bit 15 in the top nibble
  localparam logic [63:0] RBAC_ATTR_MAP [RBAC_NUM_REGS] = '{
    64'h9999_9999_5000_0044,
    64'h9999_9999_9923_6623,
    64'h9999_9999_8888_7777,
    64'h9999_9997_1111_1111
  };

  // ----------------------------------------------------------------
  // reset values and reset immunity
  // ----------------------------------------------------------------
  localparam logic [RBAC_REG_W-1:0] RBAC_RST_MAP [RBAC_NUM_REGS] = '{
    16'h0080, 16'h0022, 16'h0000, 16'h0000
  };
  localparam logic [RBAC_REG_W-1:0] RBAC_LITE_IMM_MAP [RBAC_NUM_REGS] = '{
    16'h000C, 16'h0000, 16'h0000, 16'h0100
  };
  localparam logic [RBAC_REG_W-1:0] RBAC_SOFT_IMM_MAP [RBAC_NUM_REGS] = '{
    16'h0008, 16'h0000, 16'h0000, 16'h0000
  };

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef logic [RBAC_NUM_REGS-1:0][RBAC_REG_W-1:0] rbac_bank_t;

  typedef struct packed {
    logic                   rd;
    logic                   wr;
    logic [RBAC_ADDR_W-1:0] addr;
    logic [RBAC_REG_W-1:0]  wdata;
  } rbac_req_s;

  typedef struct packed {
    logic val;
    logic seen;
  } rbac_cell_s;

  typedef struct packed {
    logic [RBAC_REG_W-1:0] rdata;
    logic                  rvalid;
    logic                  rsvd_err;
  } rbac_top_s;

endpackage

// ### logic/rbac_bit_cell.sv
module rbac_bit_cell
  import rbac_pkg::*;
#(
  parameter rbac_attr_e ATTR     = RBAC_RW,
  parameter logic       RST_VAL  = 1'b0,
  parameter logic       LITE_IMM = 1'b0,
  parameter logic       SOFT_IMM = 1'b0
)(
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  input  wire logic lite_rst_i,
  input  wire logic soft_rst_i,
  input  wire logic rd_i,
  input  wire logic wr_i,
  input  wire logic wdata_i,
  input  wire logic cond_i,
  output logic      val_o
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (ATTR == RBAC_RESERVED && RST_VAL != 1'b0)
  begin : g_bad_rsvd
    $error("reserved bit must reset to zero");
  end

  rbac_cell_s st_r;
  rbac_cell_s st_nxt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    case (ATTR)
      RBAC_RW:
      begin
        if (wr_i)
        begin
          st_nxt.val = wdata_i;
        end
      end
      RBAC_RO:
      begin
        st_nxt.val = cond_i;
      end
      RBAC_LATCH_LOW_CLEAR_ON_READ:
      begin
        if (!cond_i)
        begin
          st_nxt.val = 1'b0;
        end
        else if (rd_i)
        begin
          st_nxt.val = 1'b1;
        end
      end
      RBAC_LATCH_HIGH_CLEAR_ON_READ:
      begin
        if (cond_i)
        begin
          st_nxt.val = 1'b1;
        end
        else if (rd_i)
        begin
          st_nxt.val = 1'b0;
        end
      end
      RBAC_SELF_CLEARING:
      begin
        if (wr_i && wdata_i)
        begin
          st_nxt.val = 1'b1;
        end
        else if (st_r.val && cond_i)
        begin
          st_nxt.val = 1'b0;
        end
      end
      RBAC_SELF_SETTING:
      begin
        if (wr_i && !wdata_i)
        begin
          st_nxt.val = 1'b0;
        end
        else if (!st_r.val && cond_i)
        begin
          st_nxt.val = 1'b1;
        end
      end
      RBAC_READONLY_STICKY_HIGH:
      begin
        if (cond_i && !st_r.val)
        begin
          st_nxt.val  = 1'b1;
          st_nxt.seen = 1'b0;
        end
        else if (st_r.val)
        begin
          if ((st_r.seen || rd_i) && !cond_i)
          begin
            st_nxt.val  = 1'b0;
            st_nxt.seen = 1'b0;
          end
          else
          begin
            st_nxt.seen = st_r.seen || rd_i;
          end
        end
      end
      RBAC_WRITE_ONE_TO_CLEAR:
      begin
        if (cond_i)
        begin
          st_nxt.val = 1'b1;
        end
        else if (wr_i && wdata_i)
        begin
          st_nxt.val = 1'b0;
        end
      end
      RBAC_READ_TO_CLEAR:
      begin
        if (cond_i)
        begin
          st_nxt.val = 1'b1;
        end
        else if (rd_i)
        begin
          st_nxt.val = 1'b0;
        end
      end
      default:
      begin
        st_nxt.val  = 1'b0;
        st_nxt.seen = 1'b0;
      end
    endcase

    if (srst_i || (lite_rst_i && !LITE_IMM) || (soft_rst_i && !SOFT_IMM))
    begin
      st_nxt.val  = RST_VAL;
      st_nxt.seen = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    st_r <= st_nxt;
  end

  assign val_o = st_r.val;

endmodule // rbac_bit_cell

// ### logic/rbac_register_bank.sv
// Behaviour
// - latch-low bit holds a low until its register is read
// - latch-high bit holds a high until its register is read
// - self-clearing bit returns to zero by itself, value stays readable
// - writing zero to a self-clearing bit changes nothing
// - self-setting bit returns to one while its condition input is high, value stays readable
// - writing one to a self-setting bit changes nothing
// - read-only sticky-high bit stays one until it is read
// - after the read it follows the condition and falls when it goes
// - unread sticky-high bit stays one even if the condition goes
// - lite-reset-immune bits keep value under lite reset
// - soft-reset-immune bits keep value under software reset
// - write-one-to-clear bit clears on a written one only
// - read-to-clear bit clears after a read, writes ignored
module rbac_register_bank
  import rbac_pkg::*;
#(
  parameter int NUM_REGS = RBAC_NUM_REGS,
  parameter int REG_W    = RBAC_REG_W
)(
  input  wire logic                   sys_clk_i,
  input  wire logic                   srst_i,
  input  wire logic                   lite_rst_i,
  input  wire logic                   soft_rst_i,
  input  wire rbac_req_s              req_i,
  input  wire rbac_bank_t             cond_i,
  output logic [RBAC_REG_W-1:0]       rdata_o,
  output logic                        rvalid_o,
  output rbac_bank_t                  bank_o,
  output logic                        soft_rst_o,
  output logic                        lite_rst_o,
  output logic                        rsvd_wr_o
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (NUM_REGS != RBAC_NUM_REGS || REG_W != RBAC_REG_W)
  begin : g_bad_geom
    $error("bank geometry must match the attribute tables");
  end

  rbac_top_s                 st_r;
  rbac_top_s                 st_nxt;
  rbac_bank_t                bank_val;
  rbac_bank_t                cell_cond;
  rbac_bank_t                rsvd_mask;
  logic [RBAC_NUM_REGS-1:0]  rd_sel;
  logic [RBAC_NUM_REGS-1:0]  wr_sel;
  logic                      rsvd_hit;
  logic                      soft_rst;
  logic                      lite_rst;

  // ----------------------------------------------------------------
  // reserved bit mask from the attribute table
  // ----------------------------------------------------------------
  for (genvar r = 0; r < RBAC_NUM_REGS; r++)
  begin : g_mask_reg
    for (genvar b = 0; b < RBAC_REG_W; b++)
    begin : g_mask_bit
      assign rsvd_mask[r][b] = (RBAC_ATTR_MAP[r][4*b +: 4] == RBAC_RESERVED);
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_sel = '0;
    wr_sel = '0;
    if (req_i.addr == RBAC_IDX_CTRL)
    begin
      rd_sel[0] = req_i.rd;
      wr_sel[0] = req_i.wr;
    end
    else if (req_i.addr == RBAC_IDX_STAT)
    begin
      rd_sel[1] = req_i.rd;
      wr_sel[1] = req_i.wr;
    end
    else if (req_i.addr == RBAC_IDX_EVT)
    begin
      rd_sel[2] = req_i.rd;
      wr_sel[2] = req_i.wr;
    end
    else
    begin
      rd_sel[3] = req_i.rd;
      wr_sel[3] = req_i.wr;
    end
  end

  // software that breaks the reserved-field convention is flagged
  assign rsvd_hit = req_i.wr && |(req_i.wdata & rsvd_mask[req_i.addr]);

  // ----------------------------------------------------------------
  // internal resets, including the self-clearing request bits
  // ----------------------------------------------------------------
  assign soft_rst = soft_rst_i || bank_val[RBAC_IDX_CTRL][RBAC_CTRL_SOFT_REQ_BIT];
  assign lite_rst = lite_rst_i || bank_val[RBAC_IDX_CTRL][RBAC_CTRL_LITE_REQ_BIT];

  // ----------------------------------------------------------------
  // condition routing
  // ----------------------------------------------------------------
  always_comb
  begin
    cell_cond = cond_i;
    // reset requests complete one cycle after being set
    cell_cond[RBAC_IDX_CTRL][RBAC_CTRL_SOFT_REQ_BIT] = 1'b1;
    cell_cond[RBAC_IDX_CTRL][RBAC_CTRL_LITE_REQ_BIT] = 1'b1;
    cell_cond[RBAC_IDX_MISC][RBAC_MISC_RSVD_ERR_BIT] = rsvd_hit;
  end

  // ----------------------------------------------------------------
  // bit cells
  // ----------------------------------------------------------------
  for (genvar r = 0; r < RBAC_NUM_REGS; r++)
  begin : g_reg
    for (genvar b = 0; b < RBAC_REG_W; b++)
    begin : g_bit
      rbac_bit_cell #(
        .ATTR     (rbac_attr_e'(RBAC_ATTR_MAP[r][4*b +: 4])),
        .RST_VAL  (RBAC_RST_MAP[r][b]),
        .LITE_IMM (RBAC_LITE_IMM_MAP[r][b]),
        .SOFT_IMM (RBAC_SOFT_IMM_MAP[r][b])
      ) u_cell (
        .sys_clk_i  (sys_clk_i),
        .srst_i     (srst_i),
        .lite_rst_i (lite_rst),
        .soft_rst_i (soft_rst),
        .rd_i       (rd_sel[r]),
        .wr_i       (wr_sel[r]),
        .wdata_i    (req_i.wdata[b]),
        .cond_i     (cell_cond[r][b]),
        .val_o      (bank_val[r][b])
      );
    end
  end

  // ----------------------------------------------------------------
  // read capture: value before the read side effects take hold
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.rvalid   = req_i.rd;
    st_nxt.rsvd_err = rsvd_hit;
    if (req_i.rd)
    begin
      // reserved cells hold zero, so reserved bits read as zero
      st_nxt.rdata = bank_val[req_i.addr];
    end
    if (srst_i)
    begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o    = st_r.rdata;
  assign rvalid_o   = st_r.rvalid;
  assign rsvd_wr_o  = st_r.rsvd_err;
  assign bank_o     = bank_val;
  assign soft_rst_o = soft_rst;
  assign lite_rst_o = lite_rst;

endmodule // rbac_register_bank

// ### test/rbac_register_bank_chk.sv
module rbac_register_bank_chk
  import rbac_pkg::*;
(
  input wire logic                  sys_clk_i,
  input wire logic                  srst_i,
  input wire logic                  lite_rst_i,
  input wire logic                  soft_rst_i,
  input wire rbac_req_s             req_i,
  input wire rbac_bank_t            cond_i,
  input wire logic [RBAC_REG_W-1:0] rdata_o,
  input wire logic                  rvalid_o,
  input wire rbac_bank_t            bank_o,
  input wire logic                  soft_rst_o,
  input wire logic                  lite_rst_o,
  input wire logic                  rsvd_wr_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  wire logic q       = !soft_rst_o && !lite_rst_o;
  wire logic rds     = req_i.rd && req_i.addr == RBAC_IDX_STAT;
  wire logic wr_ctrl = req_i.wr && req_i.addr == RBAC_IDX_CTRL;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_latch_high_capture: assert property (q && cond_i[1][0] |=> bank_o[1][0])
    else $error("latch high lost");
  a_latch_low_capture: assert property (q && !cond_i[1][1] |=> !bank_o[1][1])
    else $error("latch low lost");
  a_sticky_unread: assert property (q && $rose(bank_o[1][2]) && !$past(rds)
    && !rds |=> bank_o[1][2])
    else $error("sticky dropped unread");
  a_sticky_fall: assert property (q && rds && !cond_i[1][2] |=> !bank_o[1][2])
    else $error("sticky kept after read");
  a_selfclr_start: assert property (q && wr_ctrl && req_i.wdata[0]
    |=> soft_rst_o && bank_o[0][0])
    else $error("self clear not started");
  a_selfclr_done: assert property (bank_o[0][0] && !(wr_ctrl && req_i.wdata[0])
    |=> !bank_o[0][0])
    else $error("self clear stuck");
  a_selfclr_zero_wr: assert property (q && !bank_o[0][1] && wr_ctrl && !req_i.wdata[1]
    |=> !bank_o[0][1])
    else $error("zero write set bit");
  a_ss_refill: assert property (!bank_o[0][7] && cond_i[0][7]
    && !(wr_ctrl && !req_i.wdata[7]) |=> bank_o[0][7])
    else $error("self set stuck");
  a_lite_keep: assert property (lite_rst_i && !soft_rst_o && !req_i.wr
    |=> bank_o[0][3:2] == $past(bank_o[0][3:2]) && bank_o[0][6:4] == 3'h0
        && bank_o[3][8] == $past(bank_o[3][8]))
    else $error("lite reset wrong");
  a_soft_keep: assert property (soft_rst_o && !lite_rst_o && !req_i.wr
    |=> bank_o[0][3] == $past(bank_o[0][3]) && !bank_o[0][2])
    else $error("soft reset wrong");
  a_w1c_clear: assert property (q && req_i.wr && req_i.addr == RBAC_IDX_EVT
    && req_i.wdata[0] && !cond_i[2][0] |=> !bank_o[2][0])
    else $error("one write did not clear");
  a_rdclr_read: assert property (q && req_i.rd && req_i.addr == RBAC_IDX_EVT
    && !cond_i[2][4] |=> !bank_o[2][4])
    else $error("read did not clear");

  c_soft: cover property (soft_rst_o);
  c_lite: cover property (lite_rst_o && !lite_rst_i);
  c_rsvd: cover property (rsvd_wr_o);
  c_sticky: cover property ($rose(bank_o[1][2]));
endmodule // rbac_register_bank_chk

bind rbac_register_bank rbac_register_bank_chk i_chk (
  .sys_clk_i, .srst_i, .lite_rst_i, .soft_rst_i, .req_i, .cond_i,
  .rdata_o, .rvalid_o, .bank_o, .soft_rst_o, .lite_rst_o, .rsvd_wr_o
);

// ### test/test_rbac_register_bank.sv
module test_rbac_register_bank
  import rbac_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk     = 1'b0;
  logic        srst        = 1'b1;
  logic        lite_rst    = 1'b0;
  logic        soft_rst    = 1'b0;
  rbac_req_s   req         = '0;
  rbac_bank_t  cond        = 64'h0000_0000_0022_0080;
  logic [15:0] rdata;
  logic        rvalid;
  rbac_bank_t  bank;
  logic        soft_o;
  logic        lite_o;
  logic        rsvd;
  logic [15:0] v;
  int          miscompares = 0;
  int          n_checks    = 0;

  rbac_register_bank i_rbac_register_bank (
    .sys_clk_i  (sys_clk),
    .srst_i     (srst),
    .lite_rst_i (lite_rst),
    .soft_rst_i (soft_rst),
    .req_i      (req),
    .cond_i     (cond),
    .rdata_o    (rdata),
    .rvalid_o   (rvalid),
    .bank_o     (bank),
    .soft_rst_o (soft_o),
    .lite_rst_o (lite_o),
    .rsvd_wr_o  (rsvd)
  );

  initial forever #10 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge sys_clk);
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [1:0] a);
    @(negedge sys_clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge sys_clk);
    req.rd = 1'b0;
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
    v = rdata;
  endtask

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_latch();
    @(negedge sys_clk);
    cond[1][1:0] = 2'b01;
    @(negedge sys_clk);
    cond[1][1:0] = 2'b10;
    @(negedge sys_clk);
    chk("stat_held", 16'h0021, bank[1]);
    rd(RBAC_IDX_STAT);
    chk("stat_rd", 16'h0021, v);
    chk("stat_clr", 16'h0022, bank[1]);
    @(negedge sys_clk);
    cond[1][0] = 1'b1;
    req.rd = 1'b1;
    @(negedge sys_clk);
    req.rd = 1'b0;
    cond[1][0] = 1'b0;
    chk("event_wins", 16'h0023, bank[1]);
    $display("done latch");
  endtask

  task automatic t_sticky();
    @(negedge sys_clk);
    cond[1][2] = 1'b1;
    @(negedge sys_clk);
    cond[1][2] = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("sticky_hold", 16'h0001, {15'h0000, bank[1][2]});
    rd(RBAC_IDX_STAT);
    chk("sticky_rd", 16'h0001, {15'h0000, v[2]});
    chk("sticky_fall", 16'h0000, {15'h0000, bank[1][2]});
    cond[1][2] = 1'b1;
    rd(RBAC_IDX_STAT);
    cond[1][2] = 1'b0;
    chk("sticky_persist", 16'h0001, {15'h0000, bank[1][2]});
    @(negedge sys_clk);
    chk("sticky_gone", 16'h0000, {15'h0000, bank[1][2]});
    $display("done sticky");
  endtask

  task automatic t_ctrl();
    wr(RBAC_IDX_CTRL, 16'h00FC);
    chk("ctrl_wr", 16'h00FC, bank[0]);
    wr(RBAC_IDX_CTRL, 16'h007C);
    chk("ss_clr", 16'h007C, bank[0]);
    @(negedge sys_clk);
    chk("ss_set", 16'h00FC, bank[0]);
    wr(RBAC_IDX_CTRL, 16'h00FD);
    chk("selfclr_set", 16'h00FD, bank[0]);
    chk("soft_o", 16'h0001, {15'h0000, soft_o});
    @(negedge sys_clk);
    chk("soft_rst", 16'h0088, bank[0]);
    $display("done ctrl");
  endtask

  task automatic t_evt();
    @(negedge sys_clk);
    cond[2] = 16'h00FF;
    @(negedge sys_clk);
    cond[2] = 16'h0000;
    chk("evt_set", 16'h00FF, bank[2]);
    wr(RBAC_IDX_EVT, 16'h00F5);
    chk("evt_w1c", 16'h00FA, bank[2]);
    rd(RBAC_IDX_EVT);
    chk("evt_rd", 16'h00FA, v);
    chk("evt_rdclr", 16'h000A, bank[2]);
    wr(RBAC_IDX_EVT, 16'h000A);
    chk("evt_clr", 16'h0000, bank[2]);
    $display("done evt");
  endtask

  task automatic t_misc();
    @(negedge sys_clk);
    cond[3] = 16'h00A5;
    wr(RBAC_IDX_STAT, 16'h8000);
    chk("rsvd_wr", 16'h0001, {15'h0000, rsvd});
    chk("stat_ro", 16'h0022, bank[1]);
    chk("misc", 16'h01A5, bank[3]);
    rd(RBAC_IDX_MISC);
    chk("misc_rd", 16'h01A5, v);
    wr(RBAC_IDX_CTRL, 16'h00FC);
    lite_rst = 1'b1;
    @(negedge sys_clk);
    lite_rst = 1'b0;
    chk("lite_ctrl", 16'h008C, bank[0]);
    chk("lite_misc", 16'h0100, bank[3]);
    wr(RBAC_IDX_MISC, 16'h0100);
    chk("misc_w1c", 16'h00A5, bank[3]);
    chk("rsvd_none", 16'h0000, {15'h0000, rsvd});
    $display("done misc");
  endtask

  task automatic t_rst_req();
    wr(RBAC_IDX_CTRL, 16'h00FE);
    chk("lite_req", 16'h00FE, bank[0]);
    chk("lite_o", 16'h0001, {15'h0000, lite_o});
    @(negedge sys_clk);
    chk("lite_done", 16'h008C, bank[0]);
    chk("lite_o_end", 16'h0000, {15'h0000, lite_o});
    soft_rst = 1'b1;
    @(negedge sys_clk);
    chk("soft_in", 16'h0001, {15'h0000, soft_o});
    chk("soft_pin", 16'h0088, bank[0]);
    soft_rst = 1'b0;
    @(negedge sys_clk);
    chk("soft_end", 16'h0000, {15'h0000, soft_o});
    $display("done rst_req");
  endtask

  initial
  begin
    #100000;
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    repeat (16) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    chk("ctrl_rst", 16'h0080, bank[0]);
    chk("stat_rst", 16'h0022, bank[1]);
    t_latch();
    t_sticky();
    t_ctrl();
    t_evt();
    t_misc();
    t_rst_req();
    report_and_stop();
  end
endmodule // test_rbac_register_bank
